//--- common/sra_cfg.svh
// Constants for the serial register access port, shared by both ends.
// Assumes inclusion from packages and modules; definitions only.
`ifndef SRA_CFG_SVH
`define SRA_CFG_SVH
`define SRA_DEV_ADDR 7'h1E
`define SRA_MODE_I2C 1'b0
`define SRA_MODE_SPI 1'b1
`define SRA_RW_READ 1'b1
`define SRA_RW_WRITE 1'b0
`define SRA_SPI_CMD_CYC 8
`define SRA_SPI_PAD_CYC 16
`define SRA_SPI_BYTE_CYC 24
`define SRA_CFG_ONE_ADDR 7'h15
`define SRA_CFG_ONE_3W_BIT 0
`define SRA_CFG_ONE_RST 8'h00
// Six clocks a half period: covers the device's three-clock answer lag
// plus the two sync flops in the host before it samples
`define SRA_HOST_HALF_DIV 4'h5
`endif

//--- common/sra_pkg.sv
// Types for the serial register access port.
// Assumes sra_cfg.svh on the include path.
`include "sra_cfg.svh"
package sra_pkg;
	typedef enum logic [2:0] {
		SRA_I_IDLE = 3'h0,
		SRA_I_ADDR = 3'h1,
		SRA_I_ACK = 3'h2,
		SRA_I_RX = 3'h3,
		SRA_I_TX = 3'h4,
		SRA_I_RACK = 3'h5,
		SRA_I_SKIP = 3'h6
	} sra_i2c_st_t;
	typedef enum logic [2:0] {
		SRA_H_IDLE = 3'h0,
		SRA_H_START = 3'h1,
		SRA_H_BIT = 3'h2,
		SRA_H_RSTART = 3'h3,
		SRA_H_STOP = 3'h4,
		SRA_H_SPI = 3'h5,
		SRA_H_DONE = 3'h6
	} sra_host_st_t;
endpackage

//--- common/sra_if.sv
// Link between primary and register port: I2C pins and SPI pins.
// Open-drain and shared pins resolved here from the enables (low = drive).
`timescale 1ns/100ps
`default_nettype none
interface sra_if;
	logic scl_o, scl_oe_n;
	logic sda_h_o, sda_h_oe_n;
	logic sda_d_o, sda_d_oe_n;
	logic scl, sda;
	logic sclk, cs_n;
	logic mosi_h_o, mosi_h_oe_n;
	logic mosi_d_o, mosi_d_oe_n;
	logic miso_o, miso_oe_n;
	logic mosi, miso;
	// Wired-AND with pull-ups; mosi takes the device drive ahead of the host
	assign scl = scl_oe_n | scl_o;
	assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
	assign mosi = !mosi_d_oe_n ? mosi_d_o : (!mosi_h_oe_n ? mosi_h_o : 1'b1);
	assign miso = !miso_oe_n ? miso_o : 1'b1;
	modport dev(input scl, sda, sclk, cs_n, mosi,
		output sda_d_o, sda_d_oe_n, mosi_d_o, mosi_d_oe_n, miso_o, miso_oe_n);
	modport host(input scl, sda, mosi, miso,
		output scl_o, scl_oe_n, sda_h_o, sda_h_oe_n, sclk, cs_n,
		mosi_h_o, mosi_h_oe_n);
endinterface
`default_nettype wire

//--- verilog/sra_dev.sv
// Device end: I2C and SPI secondary with a 128-byte register file.
// Assumes link pins from another domain; mode chosen by mode_sel.
// Summary of operation
// R1 - Write address then register address, both acked
// R2 - Read address acked, then selected register sent
// R3 - Primary ends read with NAK and stop
// R4 - Read pointer advances after each byte
// R5 - Burst read continues until NAK and stop
// R6 - Write data byte is acknowledged
// R7 - Written value held in addressed register
// R8 - Write pointer advances per accepted byte
// R9 - Respond only on matching seven-bit address
// R10 - SPI device is secondary only
// R11 - SPI primary uses mode 00
// R12 - Sample on rise, change on fall
// R13 - Select low frames the whole transaction
// R14 - Single byte transfer takes 24 clocks
// R15 - Each extra byte adds 8 clocks
// R16 - First SPI bit is direction
// R17 - Next seven bits are address, MSB first
// R18 - Four-wire default, three-wire when field set
// R19 - Second byte ignored; data on pulses 17-24
// R20 - Burst address increments every eight clocks
// R21 - Three-wire data pin turns at pulse 16 fall
`timescale 1ns/100ps
`default_nettype none
module sra_dev
	import sra_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mode_sel,
	sra_if.dev lnk,
	output logic wr_strobe_q,
	output logic [6:0] wr_addr_q,
	output logic [7:0] wr_data_q,
	output logic three_wire_q
);
`include "sra_cfg.svh"
	typedef struct packed {
		logic [1:0] scl_s, sda_s, sclk_s, cs_s, mosi_s;
		logic scl_p, sda_p, sclk_p;
		sra_i2c_st_t st;
		logic [3:0] bit_n;
		logic [7:0] sh;
		logic rw;
		logic [1:0] phase;
		logic [6:0] ptr;
		logic sda_oe_n, sda_o;
		logic [5:0] cyc;
		logic [7:0] tx;
		logic mosi_oe_n, miso_oe_n, so;
		logic wr_stb;
		logic [6:0] wa;
		logic [7:0] wd;
	} sra_dev_st_t;
	sra_dev_st_t s_q, s_d;
	logic [7:0] regs [0:127];
	logic scl_r, scl_f, sda_r, sda_f, sclk_r, sclk_f, start, stop;
	logic [7:0] rd_byte;
	assign rd_byte = regs[s_q.ptr];
	assign three_wire_q = regs[`SRA_CFG_ONE_ADDR][`SRA_CFG_ONE_3W_BIT];
	assign wr_strobe_q = s_q.wr_stb;
	assign wr_addr_q = s_q.wa;
	assign wr_data_q = s_q.wd;
	assign lnk.sda_d_o = s_q.sda_o;
	assign lnk.sda_d_oe_n = s_q.sda_oe_n;
	assign lnk.mosi_d_o = s_q.so;
	assign lnk.mosi_d_oe_n = s_q.mosi_oe_n;
	assign lnk.miso_o = s_q.so;
	assign lnk.miso_oe_n = s_q.miso_oe_n;
	always_comb begin
		scl_r = s_q.scl_s[1] & !s_q.scl_p;
		scl_f = !s_q.scl_s[1] & s_q.scl_p;
		sda_r = s_q.sda_s[1] & !s_q.sda_p;
		sda_f = !s_q.sda_s[1] & s_q.sda_p;
		start = sda_f & s_q.scl_s[1];
		stop = sda_r & s_q.scl_s[1];
		sclk_r = s_q.sclk_s[1] & !s_q.sclk_p;
		sclk_f = !s_q.sclk_s[1] & s_q.sclk_p;
	end
	////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.scl_s = {s_q.scl_s[0], lnk.scl};
		s_d.sda_s = {s_q.sda_s[0], lnk.sda};
		s_d.sclk_s = {s_q.sclk_s[0], lnk.sclk};
		s_d.cs_s = {s_q.cs_s[0], lnk.cs_n};
		s_d.mosi_s = {s_q.mosi_s[0], lnk.mosi};
		s_d.scl_p = s_q.scl_s[1];
		s_d.sda_p = s_q.sda_s[1];
		s_d.sclk_p = s_q.sclk_s[1];
		s_d.wr_stb = 1'b0;
		if (mode_sel == `SRA_MODE_I2C) begin
			if (stop) begin
				s_d.st = SRA_I_IDLE; // see R3, R5, R7
				s_d.sda_oe_n = 1'b1;
			end else if (start) begin
				// Also a repeated start; pointer survives it, see R2
				s_d.st = SRA_I_ADDR;
				s_d.bit_n = 4'h0;
				s_d.sda_oe_n = 1'b1;
			end else begin
				unique case (s_q.st)
				SRA_I_IDLE, SRA_I_SKIP: ;
				SRA_I_ADDR, SRA_I_RX: begin
					if (scl_r) begin
						s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
						s_d.bit_n = s_q.bit_n + 4'h1;
					end
					if (scl_f && s_q.bit_n == 4'h8) begin
						s_d.bit_n = 4'h0;
						if (s_q.st == SRA_I_ADDR) begin
							if (s_q.sh[7:1] == `SRA_DEV_ADDR) begin // see R9
								s_d.rw = s_q.sh[0];
								s_d.phase = 2'h0;
								s_d.st = SRA_I_ACK; // see R1, R2
								s_d.sda_oe_n = 1'b0;
								s_d.sda_o = 1'b0;
							end else begin
								s_d.st = SRA_I_SKIP;
							end
						end else begin
							s_d.st = SRA_I_ACK;
							s_d.sda_oe_n = 1'b0;
							s_d.sda_o = 1'b0;
							if (s_q.phase == 2'h0) begin
								s_d.ptr = s_q.sh[6:0]; // see R1
								s_d.phase = 2'h1;
							end else begin
								s_d.wr_stb = 1'b1; // see R6, R7
								s_d.wa = s_q.ptr;
								s_d.wd = s_q.sh;
								s_d.ptr = s_q.ptr + 7'h1; // see R8
							end
						end
					end
				end
				SRA_I_ACK: if (scl_f) begin
					if (s_q.rw == `SRA_RW_READ) begin
						s_d.st = SRA_I_TX; // see R2
						s_d.sh = rd_byte;
						s_d.sda_o = rd_byte[7];
						s_d.sda_oe_n = rd_byte[7];
						s_d.ptr = s_q.ptr + 7'h1; // see R4
						s_d.bit_n = 4'h1;
					end else begin
						s_d.st = SRA_I_RX;
						s_d.sda_oe_n = 1'b1;
					end
				end
				SRA_I_TX: if (scl_f) begin
					if (s_q.bit_n == 4'h8) begin
						s_d.st = SRA_I_RACK;
						s_d.sda_oe_n = 1'b1;
					end else begin
						s_d.sda_o = s_q.sh[7 - s_q.bit_n[2:0]];
						s_d.sda_oe_n = s_q.sh[7 - s_q.bit_n[2:0]];
						s_d.bit_n = s_q.bit_n + 4'h1;
					end
				end
				SRA_I_RACK: if (scl_r) begin
					// NAK lets go of the bus until stop, see R5
					s_d.st = s_q.sda_s[1] ? SRA_I_SKIP : SRA_I_ACK;
					s_d.sda_oe_n = 1'b1;
				end
				default: s_d.st = SRA_I_IDLE;
				endcase
			end
		end else if (s_q.cs_s[1]) begin
			// Select high ends any transfer, see R13, R20
			s_d.cyc = 6'h0;
			s_d.mosi_oe_n = 1'b1;
			s_d.miso_oe_n = 1'b1;
		end else begin
			if (sclk_r) begin // see R10, R11, R12
				s_d.sh = {s_q.sh[6:0], s_q.mosi_s[1]};
				s_d.cyc = (s_q.cyc == 6'd`SRA_SPI_BYTE_CYC) ?
					6'd`SRA_SPI_PAD_CYC + 6'h1 : s_q.cyc + 6'h1;
				if (s_q.cyc == 6'h0)
					s_d.rw = s_q.mosi_s[1]; // see R16
				if (s_q.cyc == 6'd`SRA_SPI_CMD_CYC - 6'h1)
					s_d.ptr = {s_q.sh[5:0], s_q.mosi_s[1]}; // see R17
				if (s_q.cyc == 6'd`SRA_SPI_BYTE_CYC - 6'h1 &&
					s_q.rw == `SRA_RW_WRITE) begin
					s_d.wr_stb = 1'b1; // see R14, R19
					s_d.wa = s_q.ptr;
					s_d.wd = {s_q.sh[6:0], s_q.mosi_s[1]};
					s_d.ptr = s_q.ptr + 7'h1; // see R15, R20
				end
			end
			if (sclk_f && s_q.rw == `SRA_RW_READ) begin
				if (s_q.cyc == 6'd`SRA_SPI_PAD_CYC ||
					s_q.cyc == 6'd`SRA_SPI_BYTE_CYC) begin
					s_d.tx = rd_byte;
					s_d.so = rd_byte[7];
					s_d.ptr = s_q.ptr + 7'h1; // see R20
					s_d.mosi_oe_n = !three_wire_q; // see R18, R21
					s_d.miso_oe_n = three_wire_q;
				end else if (s_q.cyc > 6'd`SRA_SPI_PAD_CYC) begin
					s_d.tx = {s_q.tx[6:0], 1'b0}; // see R12
					s_d.so = s_q.tx[6];
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.scl_s <= 2'h3;
			s_q.sda_s <= 2'h3;
			s_q.cs_s <= 2'h3;
			s_q.scl_p <= 1'b1;
			s_q.sda_p <= 1'b1;
			s_q.sda_oe_n <= 1'b1;
			s_q.mosi_oe_n <= 1'b1;
			s_q.miso_oe_n <= 1'b1;
			s_q.st <= SRA_I_IDLE;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
	// Register file; the mode field resets to four-wire, see R18
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 128; i++)
				regs[i] <= `SRA_CFG_ONE_RST;
		end else if (ce && s_q.wr_stb) begin
			regs[s_q.wa] <= s_q.wd;
		end
	end
endmodule
`default_nettype wire

//--- verilog/sra_host.sv
// Primary end: one transfer per go pulse over I2C or SPI.
// Assumes link pins from another domain; makes SCL/SCLK by division.
`timescale 1ns/100ps
`default_nettype none
module sra_host
	import sra_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mode_sel,
	input wire logic three_wire,
	input wire logic go,
	input wire logic rd,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] wdata,
	sra_if.host lnk,
	output logic busy_q,
	output logic done_q,
	output logic nak_q,
	output logic [7:0] rdata_q
);
`include "sra_cfg.svh"
	typedef struct packed {
		sra_host_st_t st;
		logic [3:0] div;
		logic ph;
		logic [5:0] n;
		logic [26:0] out;
		logic [7:0] in;
		logic [1:0] sda_s;
		logic rs, nak, done, busy;
		logic scl, sda_oe_n, sclk, cs_n, mo;
	} sra_host_state_t;
	sra_host_state_t h_q, h_d;
	logic tick;
	assign tick = h_q.div == `SRA_HOST_HALF_DIV;
	assign busy_q = h_q.busy;
	assign done_q = h_q.done;
	assign nak_q = h_q.nak;
	assign rdata_q = h_q.in;
	assign lnk.scl_o = 1'b0;
	assign lnk.scl_oe_n = h_q.scl;
	assign lnk.sda_h_o = 1'b0;
	assign lnk.sda_h_oe_n = h_q.sda_oe_n;
	assign lnk.sclk = h_q.sclk;
	assign lnk.cs_n = h_q.cs_n;
	assign lnk.mosi_h_o = h_q.mo;
	// Three-wire read: let go after the fall of pulse 16, see R21
	assign lnk.mosi_h_oe_n = h_q.cs_n | (three_wire & rd &
		(h_q.n > 6'h10 | (h_q.n == 6'h10 & !h_q.sclk)));
	////////////////////////////////////////////////////////////////////
	always_comb begin
		h_d = h_q;
		h_d.done = 1'b0;
		h_d.sda_s = {h_q.sda_s[0], mode_sel ?
			(three_wire ? lnk.mosi : lnk.miso) : lnk.sda};
		h_d.div = tick ? 4'h0 : h_q.div + 4'h1;
		unique case (h_q.st)
		SRA_H_IDLE: if (go) begin
			h_d.busy = 1'b1;
			h_d.nak = 1'b0;
			h_d.ph = 1'b0;
			h_d.n = 6'h0;
			h_d.div = 4'h0;
			if (mode_sel == `SRA_MODE_SPI) begin
				h_d.st = SRA_H_SPI;
				h_d.cs_n = 1'b0;
				h_d.out = {rd, reg_addr, 8'h00, wdata, 3'h0};
				h_d.mo = rd;
			end else begin
				h_d.st = SRA_H_START;
				h_d.rs = 1'b0;
				h_d.out = {`SRA_DEV_ADDR, `SRA_RW_WRITE, 1'b1,
					1'b0, reg_addr, 1'b1, rd ? 9'h1FF : {wdata, 1'b1}};
			end
		end
		SRA_H_START: if (tick) begin
			h_d.sda_oe_n = 1'b0;
			h_d.st = SRA_H_BIT;
		end
		SRA_H_RSTART: if (tick) begin
			// Drop scl first so the device lets go of its ack
			h_d.ph = !h_q.ph;
			if (!h_q.ph) begin
				h_d.scl = 1'b0;
				h_d.sda_oe_n = 1'b1;
			end else begin
				h_d.scl = 1'b1;
				h_d.st = SRA_H_START;
			end
		end
		SRA_H_BIT: if (tick) begin
			h_d.ph = !h_q.ph;
			if (!h_q.ph) begin
				h_d.scl = 1'b0;
				h_d.sda_oe_n = h_q.out[26];
			end else begin
				h_d.scl = 1'b1;
				h_d.out = {h_q.out[25:0], 1'b1};
				h_d.n = h_q.n + 6'h1;
				if (h_q.n == 6'd8 || h_q.n == 6'd17 ||
					(h_q.n == 6'd26 && !h_q.rs))
					h_d.nak = h_q.nak | h_q.sda_s[1];
				if (h_q.rs && h_q.n > 6'd17 && h_q.n < 6'd26)
					h_d.in = {h_q.in[6:0], h_q.sda_s[1]};
				if (h_q.n == 6'd17 && rd && !h_q.rs) begin
					h_d.st = SRA_H_RSTART; // repeated start, see R2
					h_d.rs = 1'b1;
					h_d.n = 6'h9;
					h_d.out = {`SRA_DEV_ADDR, `SRA_RW_READ, 1'b1,
						18'h3FFFF};
				end else if (h_q.n == 6'd26) begin
					h_d.st = SRA_H_STOP; // NAK then stop, see R3
				end
			end
		end
		SRA_H_STOP: if (tick) begin
			h_d.ph = !h_q.ph;
			if (!h_q.ph) begin
				h_d.scl = 1'b0;
				h_d.sda_oe_n = 1'b0;
			end else if (!h_q.scl) begin
				h_d.scl = 1'b1;
				h_d.ph = 1'b1;
			end else begin
				h_d.sda_oe_n = 1'b1;
				h_d.st = SRA_H_DONE;
			end
		end
		SRA_H_SPI: if (tick) begin
			// Mode 00: shift out on fall, sample on rise, see R11, R12
			h_d.sclk = !h_q.sclk;
			if (!h_q.sclk) begin
				if (h_q.n > 6'd15)
					h_d.in = {h_q.in[6:0], h_q.sda_s[1]};
				h_d.n = h_q.n + 6'h1;
			end else begin
				h_d.out = {h_q.out[25:0], 1'b0};
				h_d.mo = h_q.out[25];
				if (h_q.n == 6'd`SRA_SPI_BYTE_CYC) begin
					h_d.cs_n = 1'b1; // see R13, R14
					h_d.st = SRA_H_DONE;
				end
			end
		end
		SRA_H_DONE: begin
			h_d.busy = 1'b0;
			h_d.done = 1'b1;
			h_d.st = SRA_H_IDLE;
		end
		default: h_d.st = SRA_H_IDLE;
		endcase
	end
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			h_q <= '0;
			h_q.st <= SRA_H_IDLE;
			h_q.scl <= 1'b1;
			h_q.sda_oe_n <= 1'b1;
			h_q.cs_n <= 1'b1;
			h_q.sda_s <= 2'h3;
		end else if (ce) begin
			h_q <= h_d;
		end
	end
endmodule
`default_nettype wire

//--- tb/sra_asserts.sv
// Concurrent checks on the link between host end and device end.
// Assumes link signals sampled on the shared system clock.
`timescale 1ns/100ps
`default_nettype none
module sra_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic sda_d_oe_n,
	input wire logic mosi_d_oe_n,
	input wire logic miso_oe_n
);
	logic [5:0] pulse_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////
	// Rising sclk edges in the current frame
	always_ff @(posedge clk) begin
		if (rst || cs_n) begin
			pulse_q <= 6'h00;
		end else if ($rose(sclk)) begin
			pulse_q <= pulse_q + 6'h01;
		end
	end
	////////////////////////////////////////////////////////////////////
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("sclk not low outside a frame");
	frame_len_a: assert property ($rose(cs_n) |-> pulse_q == 6'h18)
		else $error("frame pulse count wrong");
	turn_pulse_a: assert property ($fell(mosi_d_oe_n) |->
		pulse_q == 6'h10 && !sclk)
		else $error("data pin turned at wrong pulse");
	miso_fall_a: assert property (!cs_n && $changed(miso) |-> !sclk)
		else $error("miso changed while sclk high");
	mosi_hold_a: assert property (!cs_n && sclk |-> $stable(mosi))
		else $error("mosi changed while sclk high");
	// Release may lag the select by the input synchroniser
	sel_release_a: assert property (cs_n [*5] |->
		miso_oe_n && mosi_d_oe_n)
		else $error("device drives spi pins while idle");
	cs_setup_a: assert property ($fell(cs_n) |-> !sclk [*3])
		else $error("sclk rose too soon after select");
	sclk_high_a: assert property ($rose(sclk) |=>
		sclk [*5] ##1 !sclk)
		else $error("sclk high phase wrong");
	sda_turn_a: assert property ($changed(sda_d_oe_n) |-> !scl)
		else $error("device sda changed while scl high");
	frame_c: cover property ($rose(cs_n));
	turn_c: cover property ($fell(mosi_d_oe_n));
	ack_c: cover property ($fell(sda_d_oe_n));
endmodule
`default_nettype wire

//--- tb/serial_register_access_port_tb.sv
// Bench: host end talks to device end over I2C, 4-wire and 3-wire SPI.
// Assumes both ends on one 10 MHz clock; wire bits captured on the link.
`timescale 1ns/100ps
`default_nettype none
`include "sra_cfg.svh"
module serial_register_access_port_tb;
	logic clk, rst, ce, mode_sel, three_wire, go, rd;
	logic busy_q, done_q, nak_q, wr_strobe_q, three_wire_q;
	logic [6:0] reg_addr, wr_addr_q, st_addr;
	logic [7:0] wdata, rdata_q, wr_data_q, st_data;
	logic [31:0] mosi_bits, miso_bits;
	logic [63:0] sda_bits;
	int n_errors, compares, n_pulse, n_strobe;
	sra_if lnk();
	sra_dev i_sra_dev (.clk(clk), .rst(rst), .ce(ce), .mode_sel(mode_sel),
		.lnk(lnk.dev), .wr_strobe_q(wr_strobe_q), .wr_addr_q(wr_addr_q),
		.wr_data_q(wr_data_q), .three_wire_q(three_wire_q));
	sra_host i_sra_host (.clk(clk), .rst(rst), .ce(ce), .mode_sel(mode_sel),
		.three_wire(three_wire), .go(go), .rd(rd), .reg_addr(reg_addr),
		.wdata(wdata), .lnk(lnk.host), .busy_q(busy_q), .done_q(done_q),
		.nak_q(nak_q), .rdata_q(rdata_q));
	sra_asserts i_sra_asserts (.clk(clk), .rst(rst), .scl(lnk.scl),
		.sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
		.sda_d_oe_n(lnk.sda_d_oe_n), .mosi_d_oe_n(lnk.mosi_d_oe_n),
		.miso_oe_n(lnk.miso_oe_n));
	////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (wr_strobe_q === 1'h1) begin
			st_addr <= wr_addr_q;
			st_data <= wr_data_q;
			n_strobe <= n_strobe + 1;
		end
	end
	always @(posedge lnk.sclk) begin
		if (lnk.cs_n === 1'h0) begin
			n_pulse++;
			mosi_bits = {mosi_bits[30:0], lnk.mosi};
			miso_bits = {miso_bits[30:0], lnk.miso};
		end
	end
	// Stop adds one low bit at the end of every I2C capture
	always @(posedge lnk.scl) sda_bits = {sda_bits[62:0], lnk.sda};
	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
		int i;
		n_pulse = 0;
		n_strobe = 0;
		@(posedge clk);
		#1;
		go = 1'h1;
		rd = r;
		reg_addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		go = 1'h0;
		for (i = 0; i < 2000 && done_q !== 1'h1; i++) begin
			@(posedge clk);
			#1;
		end
		check("done", done_q, 1'h1);
		repeat (20) @(posedge clk);
		#1;
	endtask
	task automatic t_i2c();
		check("reset mode", three_wire_q, 1'h0);
		xfer(`SRA_RW_WRITE, 7'h05, 8'hA5);
		check("strobes", n_strobe, 8'h01);
		check("wr reg", {st_addr, st_data}, {7'h05, 8'hA5});
		check("wr nak", nak_q, 1'h0);
		check("addr byte", sda_bits[27:19], {`SRA_DEV_ADDR, 2'h0});
		check("data byte", sda_bits[9:0], {8'hA5, 2'h0});
		xfer(`SRA_RW_READ, 7'h05, 8'h00);
		check("rd data", rdata_q, 8'hA5);
		check("rd nak", nak_q, 1'h0);
		check("rd tail", sda_bits[18:0],
			{`SRA_DEV_ADDR, 2'h2, 8'hA5, 2'h2});
		check("bus free", {lnk.scl, lnk.sda}, 2'h3);
		check("no sclk", n_pulse, 8'h00);
		$display("i2c test done");
	endtask
	task automatic t_spi4();
		mode_sel = `SRA_MODE_SPI;
		xfer(`SRA_RW_WRITE, 7'h07, 8'h3C);
		check("pulses", n_pulse, 8'h18);
		check("wr reg", {st_addr, st_data}, {7'h07, 8'h3C});
		check("cmd byte", mosi_bits[23:16], {1'h0, 7'h07});
		check("wr bits", mosi_bits[7:0], 8'h3C);
		xfer(`SRA_RW_READ, 7'h05, 8'h00);
		check("rd data", rdata_q, 8'hA5);
		check("rd cmd", mosi_bits[23:16], {1'h1, 7'h05});
		check("miso bits", miso_bits[7:0], 8'hA5);
		check("no strobe", n_strobe, 8'h00);
		$display("spi four wire test done");
	endtask
	task automatic t_spi3();
		xfer(`SRA_RW_WRITE, `SRA_CFG_ONE_ADDR, 8'h01);
		check("3w mode", three_wire_q, 1'h1);
		three_wire = 1'h1;
		xfer(`SRA_RW_READ, 7'h07, 8'h00);
		check("3w data", rdata_q, 8'h3C);
		check("3w bits", mosi_bits[7:0], 8'h3C);
		check("pulses", n_pulse, 8'h18);
		rst = 1'h1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'h0;
		three_wire = 1'h0;
		check("mode after reset", three_wire_q, 1'h0);
		// Frozen clock enable: a go must not open a frame
		ce = 1'h0;
		go = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		check("frozen", {busy_q, lnk.cs_n}, 2'h1);
		go = 1'h0;
		ce = 1'h1;
		$display("spi three wire test done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst = 1'h1;
		ce = 1'h1;
		mode_sel = `SRA_MODE_I2C;
		three_wire = 1'h0;
		go = 1'h0;
		rd = 1'h0;
		reg_addr = 7'h00;
		wdata = 8'h00;
		n_errors = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'h0;
		t_i2c();
		t_spi4();
		t_spi3();
		end_of_test();
	end
	// Whole run needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
